//--- rtl/erxdfc_pkg.sv
package erxdfc_pkg;
	localparam int ERXDFC_ADDR_W = 8;
	localparam int ERXDFC_DATA_W = 32;
	localparam int ERXDFC_TALLY_W = 16;
	// Register byte addresses.
	localparam logic [7:0] ERXDFC_TALLY_OFF = 8'h00;
	localparam logic [7:0] ERXDFC_TALLY_SET_OFF = 8'h04;
	localparam logic [7:0] ERXDFC_TALLY_CLR_OFF = 8'h08;
	localparam logic [7:0] ERXDFC_TALLY_INV_OFF = 8'h0C;
	localparam logic [7:0] ERXDFC_EVENT_OFF = 8'h10;
	localparam logic [15:0] ERXDFC_TALLY_RST = 16'h0000;
	localparam logic [15:0] ERXDFC_TALLY_ONE = 16'h0001;
	localparam int ERXDFC_OVR_BIT = 0;
	localparam logic [31:0] ERXDFC_ZERO32 = 32'h00000000;
	localparam logic [1:0] ERXDFC_LOW_BE = 2'h0;
	typedef enum logic [1:0] {ERXDFC_WR_PLAIN, ERXDFC_WR_SET, ERXDFC_WR_CLR, ERXDFC_WR_INV} erxdfc_wr_e;
endpackage

//--- rtl/erxdfc_rx_dropped_frame_counter.sv
`timescale 1ns/1ps
module erxdfc_rx_dropped_frame_counter
	import erxdfc_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Receive path events from filter and receive queue
	input wire logic rxFilterAccept,
	input wire logic rxQueueOverrunDrop,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic [3:0] regBe,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// Flags
	output logic rxOverrunFlag,
	output logic [15:0] droppedFrameTally
);
	// Live tally inside the counter and the copy that leaves on the output port.
	logic [15:0] tally;
	logic [15:0] next_droppedFrameTally;

	// Address decode of the register port.
	logic tallyHit;
	logic setHit;
	logic clrHit;
	logic invHit;
	logic eventHit;
	logic tallyFamilyHit;
	logic lowLaneOn;

	// Qualified events.
	logic dropInc;
	logic readClear;
	logic swWrite;
	erxdfc_wr_e swKind;
	logic flagWrite;
	logic flagClear;
	// Next values of the registered outputs.
	logic next_rxOverrunFlag;
	logic [31:0] next_regRdata;

	// Only receive-side inputs feed the count; the block has no transmit input at all,
	// so transmit traffic cannot disturb the tally however busy it is.
	assign dropInc = rxFilterAccept & rxQueueOverrunDrop;

	always_comb
	begin
		tallyHit = 1'h0;
		setHit = 1'h0;
		clrHit = 1'h0;
		invHit = 1'h0;
		eventHit = 1'h0;
		unique case (regAddr)
			ERXDFC_TALLY_OFF:
			begin
				tallyHit = 1'h1;
			end
			ERXDFC_TALLY_SET_OFF:
			begin
				setHit = 1'h1;
			end
			ERXDFC_TALLY_CLR_OFF:
			begin
				clrHit = 1'h1;
			end
			ERXDFC_TALLY_INV_OFF:
			begin
				invHit = 1'h1;
			end
			ERXDFC_EVENT_OFF:
			begin
				eventHit = 1'h1;
			end
			default:
			begin
				tallyHit = 1'h0;
			end
		endcase
	end

	assign tallyFamilyHit = tallyHit | setHit | clrHit | invHit;
	assign lowLaneOn = (regBe[1:0] != ERXDFC_LOW_BE);
	// Only the plain address clears on read; the alias addresses read the tally without disturbing it,
	// which gives software a way to peek at the count.
	assign readClear = regRd & tallyHit & lowLaneOn;
	assign flagWrite = regWr & eventHit & regBe[ERXDFC_OVR_BIT / 8];
	assign flagClear = flagWrite & regWdata[ERXDFC_OVR_BIT];

	// Every alias shares the lane mask of the plain write.
	always_comb
	begin
		swWrite = 1'h0;
		swKind = ERXDFC_WR_PLAIN;
		if (regWr)
		begin
			if (tallyHit)
			begin
				swWrite = 1'h1;
				swKind = ERXDFC_WR_PLAIN;
			end
			else if (setHit)
			begin
				swWrite = 1'h1;
				swKind = ERXDFC_WR_SET;
			end
			else if (clrHit)
			begin
				swWrite = 1'h1;
				swKind = ERXDFC_WR_CLR;
			end
			else if (invHit)
			begin
				swWrite = 1'h1;
				swKind = ERXDFC_WR_INV;
			end
			else
			begin
				// Writes to the event register or to unmapped addresses leave the tally alone.
				swWrite = 1'h0;
			end
		end
	end

	// Only the low half of the write data reaches the tally, so writes to bits 31-16 are dropped.
	erxdfc_tally_reg u_tally (
		.mclk(mclk),
		.srst(srst),
		.dropInc(dropInc),
		.readClear(readClear),
		.swWrite(swWrite),
		.swKind(swKind),
		.swData(regWdata[ERXDFC_TALLY_W-1:0]),
		.swBe(regBe[1:0]),
		.tally(tally)
	);

	always_comb
	begin
		next_rxOverrunFlag = rxOverrunFlag;
		// Software clears the flag by writing a one. A drop in the same cycle wins,
		// because losing an overrun report is worse than seeing a stale one.
		if (flagClear)
		begin
			next_rxOverrunFlag = 1'h0;
		end
		if (dropInc)
		begin
			next_rxOverrunFlag = 1'h1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			rxOverrunFlag <= 1'h0;
		end
		else
		begin
			rxOverrunFlag <= next_rxOverrunFlag;
		end
	end

	always_comb
	begin
		next_regRdata = ERXDFC_ZERO32;
		if (regRd)
		begin
			if (tallyFamilyHit)
			begin
				// The upper half is unimplemented and keeps its zero.
				next_regRdata[ERXDFC_TALLY_W-1:0] = tally;
			end
			if (eventHit)
			begin
				next_regRdata[ERXDFC_OVR_BIT] = rxOverrunFlag;
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			regRdata <= ERXDFC_ZERO32;
		end
		else
		begin
			regRdata <= next_regRdata;
		end
	end

	// The output copy trails the live tally by one cycle so that it comes straight from a flip-flop.
	always_comb
	begin
		next_droppedFrameTally = tally;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			droppedFrameTally <= ERXDFC_TALLY_RST;
		end
		else
		begin
			droppedFrameTally <= next_droppedFrameTally;
		end
	end
endmodule // erxdfc_rx_dropped_frame_counter

//--- rtl/erxdfc_tally_reg.sv
`timescale 1ns/1ps
// Holds the tally word and computes its next value from drops and software writes.
module erxdfc_tally_reg
	import erxdfc_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Events
	input wire logic dropInc,
	input wire logic readClear,
	// Software write
	input wire logic swWrite,
	input wire erxdfc_wr_e swKind,
	input wire logic [15:0] swData,
	input wire logic [1:0] swBe,
	// Value
	output logic [15:0] tally
);
	logic [15:0] next_tally;
	logic [15:0] wrVal;
	logic [15:0] laneMask;

	always_comb
	begin
		laneMask = {{8{swBe[1]}}, {8{swBe[0]}}};
		unique case (swKind)
			ERXDFC_WR_PLAIN: wrVal = (tally & ~laneMask) | (swData & laneMask);
			ERXDFC_WR_SET: wrVal = tally | (swData & laneMask);
			ERXDFC_WR_CLR: wrVal = tally & ~(swData & laneMask);
			ERXDFC_WR_INV: wrVal = tally ^ (swData & laneMask);
		endcase
		next_tally = tally;
		if (readClear)
			next_tally = ERXDFC_TALLY_RST;
		if (swWrite)
			next_tally = wrVal;
		// A drop in the same cycle as a clear or write is added on top, so it is never lost.
		if (dropInc)
			next_tally = next_tally + ERXDFC_TALLY_ONE;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			tally <= ERXDFC_TALLY_RST;
		else
			tally <= next_tally;
	end
endmodule // erxdfc_tally_reg

//--- tb/erxdfc_asserts.sv
`timescale 1ns/1ps
module erxdfc_asserts (
	input logic mclk,
	input logic srst,
	input logic rxFilterAccept,
	input logic rxQueueOverrunDrop,
	input logic [7:0] regAddr,
	input logic [31:0] regWdata,
	input logic [3:0] regBe,
	input logic regWr,
	input logic regRd,
	input logic [31:0] regRdata,
	input logic rxOverrunFlag,
	input logic [15:0] droppedFrameTally
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	wire hit = rxFilterAccept && rxQueueOverrunDrop;
	wire flagClr = regWr && regAddr == 8'h10 && regBe[0] && regWdata[0];
	sequence s_drop;
		hit;
	endsequence
	sequence s_quiet;
		!regWr && !regRd;
	endsequence
	sequence s_rd_clear;
		regRd && regAddr == 8'h00 && regBe[1:0] != 2'h0;
	endsequence
	a_drop_inc: assert property (s_drop ##0 s_quiet |=> ##1
		droppedFrameTally == $past(droppedFrameTally) + 16'h1) else $error("inc");
	a_flag_set: assert property (s_drop |=> rxOverrunFlag) else $error("flag");
	a_flag_hold: assert property (!hit && !flagClr |=> rxOverrunFlag == $past(rxOverrunFlag)) else $error("hold");
	a_rd_clear: assert property (s_rd_clear ##0 !hit |=> ##1
		droppedFrameTally == 16'h0) else $error("clr");
	a_rd_drop: assert property (s_rd_clear ##0 s_drop |=> ##1
		droppedFrameTally == 16'h1) else $error("clr drop");
	a_tally_steady: assert property (s_quiet ##0 !hit |=> ##1
		droppedFrameTally == $past(droppedFrameTally)) else $error("steady");
	a_upper_zero: assert property (regRd |=> regRdata[31:16] == 16'h0) else $error("upper");
	a_rst_zero: assert property ($fell(srst) |-> droppedFrameTally == 16'h0 && !rxOverrunFlag && regRdata == 32'h0)
		else $error("rst");
endmodule // erxdfc_asserts
bind erxdfc_rx_dropped_frame_counter erxdfc_asserts chk (.*);

//--- tb/erxdfc_src.sv
`timescale 1ns/1ps
module erxdfc_src (
	input logic [1:0] ev,
	output logic rxFilterAccept,
	output logic rxQueueOverrunDrop
);
	assign {rxFilterAccept, rxQueueOverrunDrop} = ev;
endmodule // erxdfc_src

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic mclk = 1'h0, srst = 1'h1, regWr = 1'h0, regRd = 1'h0;
	logic [1:0] ev = 2'h0;
	logic [3:0] regBe = 4'h0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0, regRdata;
	logic rxFilterAccept, rxQueueOverrunDrop, rxOverrunFlag;
	logic [15:0] droppedFrameTally;
	int error_cnt = 0, n_tests = 0;
	erxdfc_src src (.*);
	erxdfc_rx_dropped_frame_counter dut (.*);
	initial
		forever #10 mclk = ~mclk;
	task chk(logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp)
			$display("mismatch %0t seen %h expected %h", $time, seen, exp);
		error_cnt += seen !== exp;
	endtask
	task op(logic [3:0] s, logic [7:0] a = 8'h00, logic [31:0] d = 32'h0, logic [3:0] be = 4'h3);
		@(posedge mclk);
		{ev, regWr, regRd, regAddr, regWdata, regBe} <= {s, a, d, be};
		@(posedge mclk);
		{ev, regWr, regRd} <= 4'h0;
		#1 if (s[0])
			chk(regRdata, d);
	endtask
	task outs(logic [15:0] t, logic f);
		@(posedge mclk);
		#1 chk(droppedFrameTally, t);
		chk(rxOverrunFlag, f);
	endtask
	task test_done;
		$display("%0d errors %0d checks", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge mclk);
		srst <= 1'h0;
		op(4'h1);
		outs(16'h0, 1'h0);
		op(4'hC);
		outs(16'h1, 1'h1);
		op(4'h4);
		op(4'h1, 8'h10, 32'h1);
		op(4'h1, 8'h08, 32'h1);
		op(4'h1, , 32'h1);
		op(4'h1);
		op(4'h2, 8'h10, 32'h1, 4'h1);
		outs(16'h0, 1'h0);
		op(4'hE, 8'h10, 32'h1, 4'h1);
		outs(16'h1, 1'h1);
		op(4'hD, , 32'h1);
		op(4'h1, , 32'h1);
		op(4'h2, , 32'hFFFFFFFF, 4'hF);
		op(4'h1, , 32'hFFFF, 4'hC);
		op(4'hC);
		outs(16'h0, 1'h1);
		op(4'h2, , 32'hABCD1234, 4'h1);
		op(4'h2, 8'h0C, 32'h0101);
		op(4'h2, 8'h08, 32'h0004);
		op(4'h2, 8'h04, 32'h5000);
		op(4'h2, 8'h20, 32'hFFFF, 4'hF);
		op(4'h1, 8'h20);
		outs(16'h5131, 1'h1);
		op(4'h1, , 32'h5131);
		op(4'hC);
		@(posedge mclk);
		srst <= 1'h1;
		repeat (2) @(posedge mclk);
		srst <= 1'h0;
		outs(16'h0, 1'h0);
		op(4'h1);
		test_done;
	end
endmodule // tb_top
